// [bsc_pkg.sv]
/*
 Shared constants and carrier types for the tester status and counter block.
 Assumes a byte-wide register port with an 8-bit address.
*/
package bsc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Bus widths
   localparam int ADDR_W = 8;  // Register address width
   localparam int DATA_W = 8;  // Register data width

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets
   localparam logic [7:0] OFF_LIVE    = 8'h0c;  // Live status
   localparam logic [7:0] OFF_LATCHED = 8'h0e;  // Latched status
   localparam logic [7:0] OFF_IRQ_EN  = 8'h10;  // tester_interrupt_enable
   localparam logic [7:0] OFF_ERR0    = 8'h14;  // error_count_byte0
   localparam logic [7:0] OFF_ERR1    = 8'h15;  // error_count_byte1
   localparam logic [7:0] OFF_ERR2    = 8'h16;  // error_count_byte2
   localparam logic [7:0] OFF_BITS0   = 8'h18;  // received_bits_byte0
   localparam logic [7:0] OFF_BITS1   = 8'h19;  // received_bits_byte1
   localparam logic [7:0] OFF_BITS2   = 8'h1a;  // received_bits_byte2
   localparam logic [7:0] OFF_BITS3   = 8'h1b;  // received_bits_byte3

   ////////////////////////////////////////////////////////////////////////////
   // Flag bit positions, shared by latched status and enables
   localparam int BIT_SYNC    = 0;  // Sync change
   localparam int BIT_COUNT   = 1;  // Count became nonzero
   localparam int BIT_ERROR   = 2;  // Bit error seen
   localparam int BIT_MONITOR = 3;  // Monitoring update done
   localparam int NUM_FLAGS   = 4;  // Number of flags

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and limits
   localparam logic [3:0]  FLAGS_RST  = 4'h0;          // Latched flags
   localparam logic [3:0]  IRQ_EN_RST = 4'h0;          // Enables
   localparam logic [7:0]  RD_RST     = 8'h00;         // Read data
   localparam logic [23:0] ERR_RST    = 24'h000000;    // Error tally
   localparam logic [23:0] ERR_MAX    = 24'hffffff;    // Error tally ceiling
   localparam logic [31:0] BITS_RST   = 32'h00000000;  // Bit tally
   localparam logic [31:0] BITS_MAX   = 32'hffffffff;  // Bit tally ceiling

   ////////////////////////////////////////////////////////////////////////////
   // Carrier types
   typedef struct packed {
      logic        wr;     // Write strobe
      logic        rd;     // Read strobe
      logic [7:0]  addr;   // Byte address
      logic [7:0]  wdata;  // Write data
   } bsc_bus_req_t;

   typedef struct packed {
      logic monitor_update_done;  // Live monitoring update status
      logic bit_error;            // One pulse per detected bit error
      logic bit_valid;            // One pulse per received bit
      logic sync_lost;            // Live out-of-sync status
   } bsc_rx_status_t;

endpackage : bsc_pkg

// [bsc_top.sv]
/*
 Status latches, interrupt enables and saturating receive tallies of the
 built-in bit-error-rate tester.
 Assumes the pattern receiver drives its status synchronous to sys_clk and a
 master that follows the single-cycle strobe protocol.
*/
//
// What this block does
// [R1] Latch count-nonzero rise; clear on read
// [R2] Latch any sync change; clear on read
// [R3] Monitor-update interrupt only when enable bit 3
// [R4] Bit-error interrupt only when enable bit 2
// [R5] Count-nonzero interrupt only when enable bit 1
// [R6] Sync-change interrupt only when enable bit 0
// [R7] Count bit errors in 24 bits, reset zero
// [R8] Error tally saturates at all ones
// [R9] No error counting while out of sync
// [R10] Error tally as bytes 14h to 16h
// [R11] Count received bits in 32 bits, reset zero
// [R12] Bit tally saturates at all ones
// [R13] Bit tally frozen while out of sync
// [R14] Bit tally as bytes 18h to 1Bh
// [R15] Live sync status: 0 locked, 1 not
// [R16] Live count status: 1 when tally nonzero
// [R17] Latch every bit error; clear on read
// [R18] Latch monitor-update rise; clear on read
// [R19] Interrupt while any enabled flag is set
`timescale 1ns/1ps

module bsc_top
(
   // Clock and reset
   input  wire logic                  sys_clk,
   input  wire logic                  sys_rst,
   // Register port
   input  wire bsc_pkg::bsc_bus_req_t bus_req,
   output logic [7:0]                 rd_data_ff,
   // Pattern receiver status
   input  wire bsc_pkg::bsc_rx_status_t rx_status,
   // Interrupt request, active high level
   output logic                       irq_ff
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations

   logic [3:0]  latched_ff;        // Sticky flags
   logic [3:0]  irq_en_ff;         // Interrupt enables
   logic [3:0]  flag_set;          // Events this cycle
   logic [3:0]  flag_clr;          // Clears this cycle
   logic [23:0] error_tally_ff;    // Bit error tally
   logic [31:0] bits_tally_ff;     // Received bit tally
   logic        sync_prev_ff;      // Last sync_lost seen
   logic        count_prev_ff;     // Last count-nonzero seen
   logic        monitor_prev_ff;   // Last monitor update seen
   logic        count_nz;          // Live count-nonzero status
   logic        rd_latched;        // Read of latched register
   logic        wr_latched;        // Write of latched register
   logic [7:0]  nxt_rd_data;       // Read mux output
   logic        nxt_irq;           // Gated interrupt

   ////////////////////////////////////////////////////////////////////////////
   // Live status

   // Nonzero tally, derived straight from the counter
   assign count_nz = (error_tally_ff != bsc_pkg::ERR_RST);  // [R16]

   // Register access decode
   assign rd_latched = bus_req.rd && (bus_req.addr == bsc_pkg::OFF_LATCHED);
   assign wr_latched = bus_req.wr && (bus_req.addr == bsc_pkg::OFF_LATCHED);

   ////////////////////////////////////////////////////////////////////////////
   // Edge history

   // Previous values for change detection; reset to the idle levels
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         sync_prev_ff    <= 1'b0;
         count_prev_ff   <= 1'b0;
         monitor_prev_ff <= 1'b0;
      end
      else
      begin
         sync_prev_ff    <= rx_status.sync_lost;
         count_prev_ff   <= count_nz;
         monitor_prev_ff <= rx_status.monitor_update_done;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flag events

   // Set and clear terms per flag
   always_comb
   begin
      flag_set = 4'h0;
      // Either direction of sync counts as a change
      flag_set[bsc_pkg::BIT_SYNC]    = rx_status.sync_lost ^ sync_prev_ff;  // [R2]
      // Only the rise from zero to nonzero
      flag_set[bsc_pkg::BIT_COUNT]   = count_nz && !count_prev_ff;  // [R1]
      // Every detected error, in sync or not
      flag_set[bsc_pkg::BIT_ERROR]   = rx_status.bit_error;  // [R17]
      // Only the rise of the update status
      flag_set[bsc_pkg::BIT_MONITOR] = rx_status.monitor_update_done && !monitor_prev_ff;  // [R18]
      // Read clears all; writing ones also clears
      if (rd_latched)
      begin
         flag_clr = 4'hf;
      end
      else if (wr_latched)
      begin
         flag_clr = bus_req.wdata[3:0];
      end
      else
      begin
         flag_clr = 4'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky flags

   // One sticky bit per source; a set in the clearing cycle survives,
   // so no event is lost to a racing read
   for (genvar g = 0; g < bsc_pkg::NUM_FLAGS; g++)
   begin : g_flag
      always_ff @(posedge sys_clk)
      begin
         if (sys_rst)
         begin
            latched_ff[g] <= bsc_pkg::FLAGS_RST[g];
         end
         else if (flag_set[g])
         begin
            latched_ff[g] <= 1'b1;  // [R1] [R2] [R17] [R18]
         end
         else if (flag_clr[g])
         begin
            latched_ff[g] <= 1'b0;  // [R1] [R2] [R17] [R18]
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt enables

   // Software-written enable bits; upper bits are not stored
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         irq_en_ff <= bsc_pkg::IRQ_EN_RST;
      end
      else if (bus_req.wr && (bus_req.addr == bsc_pkg::OFF_IRQ_EN))
      begin
         irq_en_ff <= bus_req.wdata[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt output

   // Each flag passes only through its own enable
   assign nxt_irq = |(latched_ff & irq_en_ff);  // [R3] [R4] [R5] [R6] [R19]

   // Registered level; lags the flags by one cycle
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         irq_ff <= 1'b0;
      end
      else
      begin
         irq_ff <= nxt_irq;  // [R19]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Error tally

   // Counts only in sync and stops at the ceiling instead of wrapping
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         error_tally_ff <= bsc_pkg::ERR_RST;  // [R7]
      end
      else if (rx_status.bit_error && !rx_status.sync_lost  // [R9]
               && (error_tally_ff != bsc_pkg::ERR_MAX))     // [R8]
      begin
         error_tally_ff <= error_tally_ff + 24'h000001;  // [R7]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Received bit tally

   // Same policy as the error tally: frozen out of sync, saturating
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         bits_tally_ff <= bsc_pkg::BITS_RST;  // [R11]
      end
      else if (rx_status.bit_valid && !rx_status.sync_lost  // [R13]
               && (bits_tally_ff != bsc_pkg::BITS_MAX))     // [R12]
      begin
         bits_tally_ff <= bits_tally_ff + 32'h00000001;  // [R11]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux

   // Multi-byte tallies are not snapshotted; a read across bytes while
   // counting may tear, software should read in sync-stable periods
   always_comb
   begin
      nxt_rd_data = 8'h00;
      if (bus_req.rd)
      begin
         case (bus_req.addr)
            // Live status: monitor, count-nonzero, out of sync
            bsc_pkg::OFF_LIVE:
            begin
               nxt_rd_data = {4'h0, rx_status.monitor_update_done, 1'b0,
                              count_nz, rx_status.sync_lost};  // [R15] [R16]
            end
            // Sticky flags
            bsc_pkg::OFF_LATCHED: nxt_rd_data = {4'h0, latched_ff};
            // Enables
            bsc_pkg::OFF_IRQ_EN:  nxt_rd_data = {4'h0, irq_en_ff};
            // Error tally, low byte first
            bsc_pkg::OFF_ERR0:    nxt_rd_data = error_tally_ff[7:0];    // [R10]
            bsc_pkg::OFF_ERR1:    nxt_rd_data = error_tally_ff[15:8];   // [R10]
            bsc_pkg::OFF_ERR2:    nxt_rd_data = error_tally_ff[23:16];  // [R10]
            // Bit tally, low byte first
            bsc_pkg::OFF_BITS0:   nxt_rd_data = bits_tally_ff[7:0];     // [R14]
            bsc_pkg::OFF_BITS1:   nxt_rd_data = bits_tally_ff[15:8];    // [R14]
            bsc_pkg::OFF_BITS2:   nxt_rd_data = bits_tally_ff[23:16];   // [R14]
            bsc_pkg::OFF_BITS3:   nxt_rd_data = bits_tally_ff[31:24];   // [R14]
            // Unmapped reads return zero
            default:              nxt_rd_data = 8'h00;
         endcase
      end
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         rd_data_ff <= bsc_pkg::RD_RST;
      end
      else
      begin
         rd_data_ff <= nxt_rd_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   // Read of the latched register with no racing event
   sequence s_read_latched;
      rd_latched && (flag_set == 4'h0);
   endsequence

   // Read of the live status register
   sequence s_read_live;
      bus_req.rd && (bus_req.addr == bsc_pkg::OFF_LIVE);
   endsequence

   // Clearing access that meets a new event in the same cycle
   sequence s_clear_race;
      (rd_latched || wr_latched) && (flag_set != 4'h0);
   endsequence

   a_read_clears_flags: assert property (  // [R1]
      s_read_latched |=> (latched_ff == 4'h0)
                         && (rd_data_ff == {4'h0, $past(latched_ff)}))
      else $error("latched read did not clear or return flags");

   a_sync_change_latch: assert property (  // [R2]
      (rx_status.sync_lost != sync_prev_ff) |=> latched_ff[bsc_pkg::BIT_SYNC])
      else $error("sync change not latched");

   a_count_rise_latch: assert property (  // [R1]
      (count_nz && !count_prev_ff) |=> latched_ff[bsc_pkg::BIT_COUNT])
      else $error("count rise not latched");

   a_error_seen_latch: assert property (  // [R17]
      rx_status.bit_error |=> latched_ff[bsc_pkg::BIT_ERROR])
      else $error("bit error not latched");

   a_monitor_rise_latch: assert property (  // [R18]
      $rose(rx_status.monitor_update_done) && monitor_prev_ff == 1'b0
         |=> latched_ff[bsc_pkg::BIT_MONITOR])
      else $error("monitor update not latched");

   a_irq_gating: assert property (  // [R19]
      ##1 irq_ff == |($past(latched_ff) & $past(irq_en_ff)))
      else $error("interrupt does not follow enabled flags");

   a_monitor_irq_mask: assert property (  // [R3]
      (!irq_en_ff[bsc_pkg::BIT_MONITOR] && (latched_ff & irq_en_ff) == 4'h0)
         |=> !irq_ff)
      else $error("masked flag raised interrupt");

   a_err_count_step: assert property (  // [R7]
      (rx_status.bit_error && !rx_status.sync_lost && error_tally_ff != bsc_pkg::ERR_MAX)
         |=> error_tally_ff == $past(error_tally_ff) + 24'h000001)
      else $error("error tally did not step");

   a_err_saturate: assert property (  // [R8]
      (error_tally_ff == bsc_pkg::ERR_MAX) |=> (error_tally_ff == bsc_pkg::ERR_MAX))
      else $error("error tally wrapped");

   a_err_frozen_oos: assert property (  // [R9]
      rx_status.sync_lost |=> $stable(error_tally_ff))
      else $error("error tally moved out of sync");

   a_bits_count_step: assert property (  // [R11]
      (rx_status.bit_valid && !rx_status.sync_lost && bits_tally_ff != bsc_pkg::BITS_MAX)
         |=> bits_tally_ff == $past(bits_tally_ff) + 32'h00000001)
      else $error("bit tally did not step");

   a_bits_saturate: assert property (  // [R12]
      (bits_tally_ff == bsc_pkg::BITS_MAX) |=> (bits_tally_ff == bsc_pkg::BITS_MAX))
      else $error("bit tally wrapped");

   a_bits_frozen_oos: assert property (  // [R13]
      (rx_status.sync_lost || !rx_status.bit_valid) |=> $stable(bits_tally_ff))
      else $error("bit tally moved without a counted bit");

   a_err_byte_read: assert property (  // [R10]
      (bus_req.rd && bus_req.addr == bsc_pkg::OFF_ERR2)
         |=> rd_data_ff == $past(error_tally_ff[23:16]))
      else $error("error high byte misread");

   a_bits_byte_read: assert property (  // [R14]
      (bus_req.rd && bus_req.addr == bsc_pkg::OFF_BITS3)
         |=> rd_data_ff == $past(bits_tally_ff[31:24]))
      else $error("bit tally high byte misread");

   a_live_status_read: assert property (  // [R15]
      s_read_live |=> (rd_data_ff[0] == $past(rx_status.sync_lost))
                      && (rd_data_ff[1] == $past(count_nz)))
      else $error("live status misread");

   // Checked against the tally itself, not the derived status net
   a_count_nz_live: assert property (  // [R16]
      s_read_live |=> (rd_data_ff[1] == ($past(error_tally_ff) != bsc_pkg::ERR_RST))
                      && (rd_data_ff[7:2] == 6'h00 || rd_data_ff[3]))
      else $error("count-nonzero status wrong");

   // A racing event must survive the clearing access
   a_set_beats_clear: assert property (  // [R17]
      s_clear_race |=> ((latched_ff & $past(flag_set)) == $past(flag_set)))
      else $error("event lost to a clearing access");

   // Without an error pulse the error tally holds
   a_err_steady: assert property (  // [R7]
      !rx_status.bit_error |=> $stable(error_tally_ff))
      else $error("error tally moved without an error");

   // Enable writes keep the low four bits that gate each source
   a_enable_write: assert property (  // [R3] [R4] [R5] [R6]
      (bus_req.wr && bus_req.addr == bsc_pkg::OFF_IRQ_EN)
         |=> irq_en_ff == $past(bus_req.wdata[3:0]))
      else $error("enable write not stored");

endmodule : bsc_top

// [testbench.sv]
/*
 Self-checking bench for the tester status and counter block: register reads,
 receive tallies, latched flags and the gated interrupt request.
 Assumes bsc_pkg and bsc_top are compiled first; the design carries its own
 assertions, so no separate checker is bound here.
*/
`timescale 1ns/1ps

module testbench;

   ////////////////////////////////////////////////////////////////////////////
   // Signals and counters
   logic                    sys_clk;       // 100 MHz clock
   logic                    sys_rst;       // Synchronous reset
   bsc_pkg::bsc_bus_req_t   req;           // Register requests
   bsc_pkg::bsc_rx_status_t rx;            // Receiver status
   logic [7:0]              rd_data;       // Read data from the block
   logic                    irq;           // Interrupt request
   logic [7:0]              d;             // Last value read
   int                      failures;      // Mismatches
   int                      total_checks;  // Comparisons made
   int                      cycles;        // Timeout counter

   // Read expectations after the counting sequence: address, expected byte
   typedef struct packed { logic [7:0] addr; logic [7:0] exp; } bsc_row_t;
   bsc_row_t rows [14] = '{'{8'h14, 8'h04}, '{8'h15, 8'h01}, '{8'h16, 8'h00}, '{8'h18, 8'h2c},
                           '{8'h19, 8'h01}, '{8'h1a, 8'h00}, '{8'h1b, 8'h00}, '{8'h10, 8'h0f},
                           '{8'h0c, 8'h02}, '{8'h0e, 8'h07}, '{8'h0e, 8'h00}, '{8'h17, 8'h00},
                           '{8'h20, 8'h00}, '{8'h11, 8'h00}};

   ////////////////////////////////////////////////////////////////////////////
   // Design under test
   bsc_top uut
   (
      .sys_clk    (sys_clk),
      .sys_rst    (sys_rst),
      .bus_req    (req),
      .rd_data_ff (rd_data),
      .rx_status  (rx),
      .irq_ff     (irq)
   );

   // Free-running clock, 10 ns period
   always #5 sys_clk = ~sys_clk;

   // Hang guard: the whole run needs well under a thousand cycles
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         failures++;
         complete_run();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Tasks
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   // Reset held ten cycles, inputs idle meanwhile
   task automatic do_reset();
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      req     <= '0;
      rx      <= '0;
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
   endtask : do_reset

   // One-cycle write strobe
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge sys_clk);
      req.wr    <= 1'b1;
      req.addr  <= a;
      req.wdata <= v;
      @(posedge sys_clk);
      req.wr    <= 1'b0;
   endtask : bus_wr

   // One-cycle read strobe; data is taken in the following cycle only
   task automatic bus_rd(input logic [7:0] a);
      @(posedge sys_clk);
      req.rd   <= 1'b1;
      req.addr <= a;
      @(posedge sys_clk);
      req.rd   <= 1'b0;
      #1 d = rd_data;
   endtask : bus_rd

   // Back-to-back receiver pulses, then idle
   task automatic pulse(input logic e, input logic v, input int n);
      repeat (n)
      begin
         @(posedge sys_clk);
         rx.bit_error <= e;
         rx.bit_valid <= v;
      end
      @(posedge sys_clk);
      rx.bit_error <= 1'b0;
      rx.bit_valid <= 1'b0;
   endtask : pulse

   // Raise one flag source: 0 sync toggle, 1 counted error, 2 error, 3 monitor rise
   task automatic fire(input int j);
      if (j == 0)
      begin
         @(posedge sys_clk);
         rx.sync_lost <= ~rx.sync_lost;
      end
      else if (j == 3)
      begin
         @(posedge sys_clk);
         rx.monitor_update_done <= 1'b1;
         @(posedge sys_clk);
         rx.monitor_update_done <= 1'b0;
      end
      else
      begin
         // An error counts only in sync, which the count flag needs
         if (j == 1)
         begin
            @(posedge sys_clk);
            rx.sync_lost <= 1'b0;
         end
         pulse(1'b1, 1'b0, 1);
      end
   endtask : fire

   // Let flag and interrupt registers land
   task automatic settle();
      repeat (3) @(posedge sys_clk);
      #1;
   endtask : settle

   task automatic complete_run();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      sys_clk      = 1'b0;
      sys_rst      = 1'b1;
      req          = '0;
      rx           = '0;
      failures     = 0;
      total_checks = 0;
      cycles       = 0;
      do_reset();
      // Every address from 0Ch to 1Bh, mapped or not, reads zero after reset
      for (int a = 8'h0c; a <= 8'h1b; a++)
      begin
         bus_rd(8'(a));
         chk($sformatf("reset value %h", a), 8'h00, d);
      end
      chk("irq after reset", 1'b0, irq);
      bus_wr(bsc_pkg::OFF_IRQ_EN, 8'hff);
      // Multi-byte tallies in sync; saturation is out of reach in a short run
      pulse(1'b1, 1'b1, 260);
      pulse(1'b0, 1'b1, 40);
      @(posedge sys_clk);
      rx.sync_lost <= 1'b1;
      pulse(1'b1, 1'b1, 10);
      bus_rd(bsc_pkg::OFF_LIVE);
      chk("live while out of sync", 8'h03, d);
      @(posedge sys_clk);
      rx.sync_lost <= 1'b0;
      // Table of reads: tallies frozen out of sync, byte order, enables, flags
      foreach (rows[k])
      begin
         bus_rd(rows[k].addr);
         chk($sformatf("reg %h", rows[k].addr), rows[k].exp, d);
      end
      @(posedge sys_clk);
      #1;
      chk("read data idle", 8'h00, rd_data);
      // Each enable alone: other sources, bar the count source for enable 2, stay silent; its own source fires
      for (int i = 0; i < 4; i++)
      begin
         do_reset();
         bus_wr(bsc_pkg::OFF_IRQ_EN, 8'h01 << i);
         for (int j = 0; j < 4; j++)
            if (j != i && !(i == 2 && j == 1))
               fire(j);
         settle();
         chk($sformatf("irq masked %0d", i), 1'b0, irq);
         fire(i);
         settle();
         chk($sformatf("irq raised %0d", i), 1'b1, irq);
         bus_rd(bsc_pkg::OFF_LATCHED);
         chk($sformatf("flag latched %0d", i), 1'b1, d[i]);
         settle();
         chk($sformatf("irq cleared %0d", i), 1'b0, irq);
      end
      // Writing ones clears just those flags, the rest stay set
      fire(2);
      fire(3);
      bus_wr(bsc_pkg::OFF_LATCHED, 8'h04);
      bus_rd(bsc_pkg::OFF_LATCHED);
      chk("write-one clear", 8'h08, d);
      // An error in the cycle of a clearing read outlives the read
      @(posedge sys_clk);
      req.rd       <= 1'b1;
      req.addr     <= bsc_pkg::OFF_LATCHED;
      rx.bit_error <= 1'b1;
      @(posedge sys_clk);
      req.rd       <= 1'b0;
      rx.bit_error <= 1'b0;
      bus_rd(bsc_pkg::OFF_LATCHED);
      chk("set beats clear", 8'h04, d);
      complete_run();
   end

endmodule : testbench
